/* inc/ops_cfg.svh */
// address map, field positions and timing figures of the program sequencer
`ifndef OPS_CFG_SVH
`define OPS_CFG_SVH
`define OPS_ADR_W      19
`define OPS_CTRL_ADR   19'h0_0000
`define OPS_ARR_SEL    18
`define OPS_USER_LO    16'hBE00
`define OPS_USER_HI    16'hFDFF
`define OPS_VEC_LO     16'hFFD2
`define OPS_VEC_HI     16'hFFFF
`define OPS_USER_SIZE  16'h4000
`define OPS_DEPTH      16430
`define OPS_B_PGM      0
`define OPS_B_LAT      1
`define OPS_B_CAP      2
`define OPS_B_BUSY     3
`define OPS_B_DONE     4
`define OPS_BYTE_ZERO  8'h00
`define OPS_WORD_ZERO  32'h0000_0000
`define OPS_CLK_NS     4
`define OPS_PULSE_NS   1000000
`endif

/* inc/ops_pkg.sv */
// types shared by the program sequencer
package ops_pkg;
  typedef enum logic [1:0]
  {
    OPS_IDLE  = 2'b01,
    OPS_CLEAR = 2'b10
  } ops_state_e;
  typedef logic [14:0] ops_index_t;
  typedef logic [15:0] ops_addr_t;
endpackage

/* hdl/ops_sequencer.sv */
// byte programming sequencer for the one-time programmable array
`timescale 1ns/1ps
`include "ops_cfg.svh"

// Notes on behaviour
// - never-programmed or erased array bytes read as zero.
// - only the user range and vector range are valid array addresses.
// - programming only ORs ones into a byte, never clears bits.
// - latch bit is read/write; set captures bus writes, clear resumes normal use.
// - clearing the latch bit clears the program voltage bit too.
// - program voltage bit sets only if latch bit was already set.
// - writing both bits at once with the latch clear sets only the latch bit.
// - reset clears the program voltage bit, disconnecting supply.
// - with latch set, only writes to valid array addresses are captured.
// - after first capture, further valid array writes are ignored.
// - with latch set, array reads return the captured data.
// - no valid capture means the supply is never applied.
// - supply reaches array only with voltage bit set and a capture held.
// - supply is removed as soon as the voltage bit clears.
// - array contents are hidden from outside access modes.
module ops_sequencer #(
  parameter int PULSE_NS       = `OPS_PULSE_NS,
  parameter int PULSE_CYCLES   = (PULSE_NS + `OPS_CLK_NS - 1) / `OPS_CLK_NS,
  parameter int DEPTH          = `OPS_DEPTH,
  parameter bit CLEAR_ON_RESET = 1'b1
)
(
  // system
  input  wire logic                    clock,
  input  wire logic                    rst,
  // wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [`OPS_ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic                         wb_ack_o,
  output logic [31:0]                  wb_dat_o,
  // pins
  input  wire logic                    interrupt_program_voltage_pin,
  input  wire logic                    uv_erase_pin,
  input  wire logic                    ext_access_pin,
  // array supply and status
  output logic                         array_supply_on,
  output logic                         array_busy
);

  // array storage
  logic [7:0]              mem [DEPTH];

  // control and capture state
  logic                    bus_latch_enable;
  logic                    program_voltage_enable;
  logic                    captured;
  ops_pkg::ops_index_t     cap_index;
  logic [7:0]              cap_data;
  logic                    prog_done;
  logic [31:0]             pulse_cnt;

  // clearing sweep
  ops_pkg::ops_state_e     state;
  ops_pkg::ops_index_t     clr_index;

  // pin synchronisers
  logic [1:0]              hv_sync;
  logic [1:0]              erase_sync;
  logic                    erase_seen;
  logic [1:0]              ext_sync;

  // bus decode
  logic                    req;
  logic                    ctrl_hit;
  logic                    arr_hit;
  ops_pkg::ops_addr_t      cpu_addr;
  logic                    arr_valid;
  ops_pkg::ops_index_t     arr_idx;
  logic                    ctrl_wr;
  logic                    arr_wr;
  logic                    commit;
  logic                    erase_req;

  // next values
  logic                    next_latch;
  logic                    next_pgm;
  logic                    next_cap;
  logic [31:0]             next_rdata;

  function automatic logic addr_valid(input ops_pkg::ops_addr_t a);
    addr_valid = ((a >= `OPS_USER_LO) && (a <= `OPS_USER_HI)) ||
                 ((a >= `OPS_VEC_LO) && (a <= `OPS_VEC_HI));
  endfunction

  function automatic ops_pkg::ops_index_t addr_index(input ops_pkg::ops_addr_t a);
    ops_pkg::ops_addr_t off;
    if (a >= `OPS_VEC_LO)
    begin
      off = a - `OPS_VEC_LO + `OPS_USER_SIZE;
    end
    else
    begin
      off = a - `OPS_USER_LO;
    end
    addr_index = off[14:0];
  endfunction

  assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign cpu_addr  = wb_adr_i[17:2];
  assign arr_hit   = wb_adr_i[`OPS_ARR_SEL];
  assign ctrl_hit  = (wb_adr_i == `OPS_CTRL_ADR);
  assign arr_valid = addr_valid(cpu_addr);
  assign arr_idx   = addr_index(cpu_addr);
  assign ctrl_wr   = req & wb_we_i & ctrl_hit & wb_sel_i[0];
  assign arr_wr    = req & wb_we_i & arr_hit & wb_sel_i[0];
  assign erase_req = erase_sync[1] & ~erase_seen;

  // pin synchronisers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      hv_sync    <= 2'h0;
      erase_sync <= 2'h0;
      erase_seen <= 1'b0;
      ext_sync   <= 2'h0;
    end
    else
    begin
      hv_sync    <= {hv_sync[0], interrupt_program_voltage_pin};
      erase_sync <= {erase_sync[0], uv_erase_pin};
      erase_seen <= erase_sync[1];
      ext_sync   <= {ext_sync[0], ext_access_pin};
    end
  end

  // control register next values
  always_comb
  begin
    next_latch = bus_latch_enable;
    next_pgm   = program_voltage_enable;
    if (ctrl_wr)
    begin
      next_latch = wb_dat_i[`OPS_B_LAT];
      // voltage bit needs the latch set before and after this write
      next_pgm   = wb_dat_i[`OPS_B_PGM] & bus_latch_enable
                   & wb_dat_i[`OPS_B_LAT];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bus_latch_enable       <= 1'b0;
      program_voltage_enable <= 1'b0;
    end
    else
    begin
      bus_latch_enable       <= next_latch;
      program_voltage_enable <= next_pgm;
    end
  end

  // capture of the first valid array write
  always_comb
  begin
    next_cap = captured;
    if (!next_latch)
    begin
      next_cap = 1'b0;
    end
    else if (bus_latch_enable && arr_wr && arr_valid)
    begin
      next_cap = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      captured  <= 1'b0;
      cap_index <= 15'h0000;
      cap_data  <= `OPS_BYTE_ZERO;
    end
    else
    begin
      captured <= next_cap;
      if (bus_latch_enable && arr_wr && arr_valid && !captured)
      begin
        cap_index <= arr_idx;
        cap_data  <= wb_dat_i[7:0];
      end
    end
  end

  // supply switch follows the control bit on the same edge
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      array_supply_on <= 1'b0;
    end
    else
    begin
      array_supply_on <= next_pgm & next_cap;
    end
  end

  // programming pulse timer, needs high voltage present on the pin
  assign commit = array_supply_on & hv_sync[1] & ~prog_done
                  & (pulse_cnt == 32'(PULSE_CYCLES - 1));

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pulse_cnt <= 32'h0000_0000;
      prog_done <= 1'b0;
    end
    else
    begin
      if (!array_supply_on || !hv_sync[1] || prog_done)
      begin
        pulse_cnt <= 32'h0000_0000;
      end
      else
      begin
        pulse_cnt <= pulse_cnt + 32'h0000_0001;
      end
      if (!bus_latch_enable)
      begin
        prog_done <= 1'b0;
      end
      else if (commit)
      begin
        prog_done <= 1'b1;
      end
    end
  end

  // clearing sweep, at reset and on an erase request
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state      <= CLEAR_ON_RESET ? ops_pkg::OPS_CLEAR : ops_pkg::OPS_IDLE;
      array_busy <= CLEAR_ON_RESET;
      clr_index  <= 15'h0000;
    end
    else
    begin
      unique case (state)
        ops_pkg::OPS_IDLE:
        begin
          clr_index <= 15'h0000;
          if (erase_req)
          begin
            state      <= ops_pkg::OPS_CLEAR;
            array_busy <= 1'b1;
          end
        end
        ops_pkg::OPS_CLEAR:
        begin
          clr_index <= clr_index + 15'h0001;
          if (clr_index == 15'(DEPTH - 1))
          begin
            state      <= ops_pkg::OPS_IDLE;
            array_busy <= 1'b0;
          end
        end
      endcase
    end
  end

  // array write port
  always_ff @(posedge clock)
  begin
    if (state == ops_pkg::OPS_CLEAR)
    begin
      mem[clr_index] <= `OPS_BYTE_ZERO;
    end
    else if (commit)
    begin
      mem[cap_index] <= mem[cap_index] | cap_data;
    end
  end

  // read data
  always_comb
  begin
    next_rdata = `OPS_WORD_ZERO;
    if (ctrl_hit)
    begin
      next_rdata[`OPS_B_PGM]  = program_voltage_enable;
      next_rdata[`OPS_B_LAT]  = bus_latch_enable;
      next_rdata[`OPS_B_CAP]  = captured;
      next_rdata[`OPS_B_BUSY] = array_busy;
      next_rdata[`OPS_B_DONE] = prog_done;
    end
    else if (arr_hit && arr_valid)
    begin
      if (bus_latch_enable)
      begin
        next_rdata[7:0] = captured ? cap_data : `OPS_BYTE_ZERO;
      end
      else if (ext_sync[1] || state == ops_pkg::OPS_CLEAR)
      begin
        next_rdata[7:0] = `OPS_BYTE_ZERO;
      end
      else
      begin
        next_rdata[7:0] = mem[arr_idx];
      end
    end
  end

  // wishbone answer, one cycle after the request
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `OPS_WORD_ZERO;
    end
    else
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
      begin
        wb_dat_o <= next_rdata;
      end
    end
  end

endmodule

/* bench/ops_sequencer_props.sv */
// checker for the program sequencer bus and supply behaviour
`timescale 1ns/1ps
`include "ops_cfg.svh"
module ops_sequencer_props (
  // system
  input wire logic                  clock,
  input wire logic                  rst,
  // wishbone
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [`OPS_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic                  wb_ack_o,
  input wire logic [31:0]           wb_dat_o,
  // pins and status
  input wire logic                  interrupt_program_voltage_pin,
  input wire logic                  uv_erase_pin,
  input wire logic                  ext_access_pin,
  input wire logic                  array_supply_on,
  input wire logic                  array_busy
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // latch bit as last written by the core
  logic latch_copy;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      latch_copy <= 1'b0;
    end
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == `OPS_CTRL_ADR
             && wb_sel_i[0])
    begin
      latch_copy <= wb_dat_i[`OPS_B_LAT];
    end
  end
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ctrl_wr;
    s_take ##0 (wb_we_i && wb_adr_i == `OPS_CTRL_ADR && wb_sel_i[0]);
  endsequence
  sequence s_read;
    s_take ##0 !wb_we_i;
  endsequence
  a_ack_next: assert property (s_take |=> wb_ack_o) else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_supply_cause: assert property ($rose(array_supply_on) |-> wb_ack_o && wb_we_i
    && (wb_adr_i[`OPS_ARR_SEL] || (wb_adr_i == `OPS_CTRL_ADR && wb_dat_i[1:0] == 2'h3)))
    else $error("supply rose alone");
  a_supply_drop: assert property (s_ctrl_wr ##0 wb_dat_i[1:0] != 2'h3
    |=> !array_supply_on) else $error("supply kept after clear");
  a_supply_hold: assert property (array_supply_on && !(wb_stb_i && wb_we_i)
    |=> array_supply_on) else $error("supply dropped alone");
  a_ctrl_unused: assert property (s_read ##0 wb_adr_i == `OPS_CTRL_ADR
    |=> wb_dat_o[31:5] == 27'h000_0000) else $error("unused control bits set");
  a_unmapped_zero: assert property (s_read ##0 !wb_adr_i[`OPS_ARR_SEL]
    && wb_adr_i != `OPS_CTRL_ADR |=> wb_dat_o == `OPS_WORD_ZERO) else $error("unmapped read");
  a_busy_blank: assert property (s_read ##0 wb_adr_i[`OPS_ARR_SEL] && array_busy
    && !latch_copy |=> wb_dat_o == `OPS_WORD_ZERO) else $error("array read during sweep");
  a_secure_read: assert property (ext_access_pin[*4] ##0 s_read ##0 wb_adr_i[`OPS_ARR_SEL]
    && !latch_copy |=> wb_dat_o == `OPS_WORD_ZERO) else $error("array visible outside");
endmodule

bind ops_sequencer ops_sequencer_props u_props (.clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .interrupt_program_voltage_pin,
  .uv_erase_pin, .ext_access_pin, .array_supply_on, .array_busy);

/* bench/ops_cpu_model.sv */
// bus master model of the processor core
`timescale 1ns/1ps
`include "ops_cfg.svh"
module ops_cpu_model (
  // system
  input  wire logic                  clock,
  // wishbone master
  output logic                       wb_cyc,
  output logic                       wb_stb,
  output logic                       wb_we,
  output logic [`OPS_ADR_W-1:0]      wb_adr,
  output logic [3:0]                 wb_sel,
  output logic [31:0]                wb_dat_w,
  input  wire logic                  wb_ack,
  input  wire logic [31:0]           wb_dat_r
);
  initial
  begin
    wb_cyc = 1'h0;
    wb_stb = 1'h0;
    wb_we = 1'h0;
    wb_adr = '0;
    wb_sel = 4'hF;
    wb_dat_w = '0;
  end
  // one request, held until ack is sampled, then one idle cycle
  task automatic xfer(input logic we, input logic [`OPS_ADR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    @(posedge clock);
    // without an ack, only the bench timeout ends this wait
    while (wb_ack !== 1'h1)
    begin
      @(posedge clock);
    end
    q = wb_dat_r;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    wb_adr <= ~a;
    wb_dat_w <= ~d;
    @(posedge clock);
  endtask
endmodule

/* bench/tb_otp_program_sequencer.sv */
// self-checking bench of the program sequencer
`timescale 1ns/1ps
`include "ops_cfg.svh"
module tb_otp_program_sequencer;
  localparam int PULSE = 20;
  logic        clock, rst, vpp, uv, ext, cyc, stb, we, ack, supply, busy;
  logic [18:0] adr;
  logic [3:0]  sel;
  logic [31:0] dw, dr, q;
  int          fails, checks, cycles;
  logic [7:0]  wr_v [6] = '{8'h03, 8'h03, 8'h01, 8'h01, 8'h02, 8'h00};
  logic [7:0]  ex_v [6] = '{8'h02, 8'h03, 8'h00, 8'h00, 8'h02, 8'h00};
  ops_sequencer #(.PULSE_CYCLES(PULSE)) dut (.clock, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_ack_o(ack),
    .wb_dat_o(dr), .interrupt_program_voltage_pin(vpp), .uv_erase_pin(uv),
    .ext_access_pin(ext), .array_supply_on(supply), .array_busy(busy));
  ops_cpu_model cpu (.clock, .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr),
    .wb_sel(sel), .wb_dat_w(dw), .wb_ack(ack), .wb_dat_r(dr));
  initial
  begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [18:0] fa(input logic [15:0] a);
    return {1'h1, a, 2'h0};
  endfunction
  task automatic wr(input logic [18:0] a, input logic [31:0] d);
    cpu.xfer(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [18:0] a, input logic [31:0] e);
    cpu.xfer(1'h0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  task automatic sweep_wait();
    repeat (8) @(posedge clock);
    while (busy !== 1'h0)
      @(posedge clock);
  endtask
  // voltage bit, pulse time, then clear both bits
  task automatic fire();
    wr(0, 32'h0000_0003);
    chk({31'h0, supply}, 1);
    repeat (PULSE + 8) @(posedge clock);
    wr(0, 32'h0000_0000);
    chk({31'h0, supply}, 0);
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 70000)
    begin
      fails++;
      print_verdict();
    end
  end
  initial
  begin
    rst = 1'h1;
    vpp = 1'h0;
    uv = 1'h0;
    ext = 1'h0;
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    rd(0, 32'h0000_0008);
    rd(fa(16'hBE00), 0);
    sweep_wait();
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      wr(0, {24'h00_0000, wr_v[i]});
      rd(0, {24'h00_0000, ex_v[i]});
    end
    $display("test control rows done");
    vpp <= 1'h1;
    wr(0, 32'h0000_0002);
    wr(fa(16'h8000), 32'h0000_0055);
    wr(0, 32'h0000_0003);
    chk({31'h0, supply}, 0);
    rd(0, 32'h0000_0003);
    wr(0, 32'h0000_0000);
    wr(0, 32'h0000_0002);
    wr(fa(16'hFFD2), 32'h0000_005A);
    wr(fa(16'hBE00), 32'h0000_00FF);
    rd(fa(16'hBE01), 32'h0000_005A);
    fire();
    rd(fa(16'hFFD2), 32'h0000_005A);
    rd(fa(16'hBE00), 0);
    wr(0, 32'h0000_0002);
    wr(fa(16'hFFD2), 32'h0000_000F);
    fire();
    rd(fa(16'hFFD2), 32'h0000_005F);
    $display("test programming done");
    ext <= 1'h1;
    repeat (4) @(posedge clock);
    rd(fa(16'hFFD2), 0);
    ext <= 1'h0;
    wr(19'h0_0004, 32'h0000_00FF);
    rd(19'h0_0004, 0);
    uv <= 1'h1;
    repeat (4) @(posedge clock);
    uv <= 1'h0;
    sweep_wait();
    rd(fa(16'hFFD2), 0);
    $display("test security and erase done");
    wr(0, 32'h0000_0002);
    wr(fa(16'hBE00), 32'h0000_0001);
    wr(0, 32'h0000_0003);
    chk({31'h0, supply}, 1);
    rst <= 1'h1;
    repeat (2) @(posedge clock);
    chk({31'h0, supply}, 0);
    rst <= 1'h0;
    @(posedge clock);
    chk({31'h0, busy}, 1);
    rd(0, 32'h0000_0008);
    sweep_wait();
    rd(fa(16'hBE00), 0);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
